// ===== rtl/swfp_regs.v
`timescale 1ns/1ns
`include "swfp_defs.vh"

module swfp_regs #(
    parameter [3:0] REV_ID = 4'h9 // Arbitrary value
) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    output reg reg_rvalid_q,
    input wire strap_drive,
    input wire lkp_valid,
    input wire [1:0] lkp_class,
    input wire [47:0] lkp_da,
    output reg fwd_valid_q,
    output reg fwd_special_q,
    output reg [4:0] fwd_port_map_q,
    output reg self_drop_q,
    input wire tos_valid,
    input wire [7:0] tos_byte,
    output reg prio_valid_q,
    output reg [1:0] prio_q,
    output reg [1:0] drive_strength_q,
    output reg [1:0] ingress_period_q,
    output reg egress_queue_mode_q,
    output reg pvid_per_source_q
);

    reg [5:0] uuc_q;
    reg [5:0] uuc_d;
    reg [5:0] umc_q;
    reg [5:0] umc_d;
    reg [5:0] uvid_q;
    reg [5:0] uvid_d;
    reg [6:0] sfip_q;
    reg [6:0] sfip_d;
    reg [47:0] mac_q;
    reg [47:0] mac_d;
    reg [15:0] dscp_q;
    reg [15:0] dscp_d;
    reg [1:0] drv_q;
    reg [1:0] drv_d;
    reg [1:0] rate_q;
    reg [1:0] rate_d;
    reg [1:0] rate_per_q;
    reg [1:0] rate_per_d;
    reg strap_s1_q;
    reg strap_s2_q;
    reg strap_done_q;
    reg [7:0] rd_d;
    reg [5:0] sel_d;
    reg [4:0] map_d;
    reg self_hit_d;
    reg [1:0] prio_d;
    wire wr_uuc;
    wire wr_umc;
    wire wr_uvid;
    wire wr_sfip;
    wire wr_rate;
    wire wr_dscp0;
    wire wr_dscp1;
    wire wr_mac;
    wire [127:0] dscp_all;

    // Entries beyond code 7 live in other registers and read as zero here
    assign dscp_all = {112'h0, dscp_q};

    function [1:0] dscp_pick;
        input [127:0] tbl;
        input [5:0] code;
        begin
            dscp_pick = tbl[{code, 1'b0} +: 2];
        end
    endfunction

    function [7:0] mac_byte;
        input [47:0] mac;
        input [2:0] idx;
        begin
            mac_byte = mac[(3'd5 - idx) * 8 +: 8];
        end
    endfunction

    function [47:0] mac_put;
        input [47:0] mac;
        input [2:0] idx;
        input [7:0] val;
        begin
            mac_put = mac;
            mac_put[(3'd5 - idx) * 8 +: 8] = val;
        end
    endfunction

    function mac_sel;
        input [7:0] addr;
        begin
            mac_sel = (addr >= `SWFP_ADDR_MAC0) && (addr <= `SWFP_ADDR_MAC5);
        end
    endfunction

    // Disabled class forwards to no port specially
    function [4:0] fwd_map;
        input [5:0] ctrl;
        begin
            fwd_map = ctrl[`SWFP_BIT_FWD_EN] ? ctrl[4:0] : 5'h00;
        end
    endfunction

    // One write strobe per field group
    assign wr_uuc = reg_wr && (reg_addr == `SWFP_ADDR_UUC);
    assign wr_umc = reg_wr && (reg_addr == `SWFP_ADDR_UMC);
    assign wr_uvid = reg_wr && (reg_addr == `SWFP_ADDR_UVID);
    assign wr_sfip = reg_wr && (reg_addr == `SWFP_ADDR_SFIP);
    assign wr_rate = reg_wr && (reg_addr == `SWFP_ADDR_RATE);
    assign wr_dscp0 = reg_wr && (reg_addr == `SWFP_ADDR_DSCP0);
    assign wr_dscp1 = reg_wr && (reg_addr == `SWFP_ADDR_DSCP1);
    assign wr_mac = reg_wr && mac_sel(reg_addr);

    // Next values of the writable fields; read-only bits are never stored
    always @* begin
        uuc_d = uuc_q;
        umc_d = umc_q;
        uvid_d = uvid_q;
        sfip_d = sfip_q;
        rate_per_d = rate_per_q;
        rate_d = rate_q;
        dscp_d = dscp_q;
        mac_d = mac_q;
        if (wr_uuc) begin
            uuc_d = reg_wdata[5:0];
        end
        if (wr_umc) begin
            umc_d = reg_wdata[5:0];
        end
        if (wr_uvid) begin
            uvid_d = reg_wdata[5:0];
        end
        if (wr_sfip) begin
            sfip_d = reg_wdata[6:0];
        end
        if (wr_rate) begin
            rate_per_d = reg_wdata[5:4];
            rate_d = reg_wdata[`SWFP_BIT_EGR_QUEUE:`SWFP_BIT_PVID_SEL];
        end
        if (wr_dscp0) begin
            dscp_d[7:0] = reg_wdata;
        end
        if (wr_dscp1) begin
            dscp_d[15:8] = reg_wdata;
        end
        if (wr_mac) begin
            mac_d = mac_put(mac_q, reg_addr[2:0], reg_wdata);
        end
    end

    // Strap taken once, at the first edge after reset; a write overrides it
    always @* begin
        drv_d = drv_q;
        if (!strap_done_q) begin
            drv_d = {~strap_s2_q, strap_s2_q};
        end
        if (wr_umc) begin
            drv_d = reg_wdata[7:6];
        end
    end

    // Not reset, so the strap level has passed both stages by release
    always @(posedge clk_sys) begin
        strap_s1_q <= strap_drive;
        strap_s2_q <= strap_s1_q;
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            uuc_q <= `SWFP_RST_MAP;
            umc_q <= `SWFP_RST_MAP;
            uvid_q <= `SWFP_RST_MAP;
            sfip_q <= `SWFP_RST_SFIP;
            mac_q <= `SWFP_RST_MAC;
            dscp_q <= `SWFP_RST_DSCP;
            drv_q <= `SWFP_RST_DRV;
            rate_q <= `SWFP_RST_EGR;
            rate_per_q <= `SWFP_RST_RATE_PER;
            strap_done_q <= 1'b0;
        end else begin
            uuc_q <= uuc_d;
            umc_q <= umc_d;
            uvid_q <= uvid_d;
            sfip_q <= sfip_d;
            mac_q <= mac_d;
            dscp_q <= dscp_d;
            drv_q <= drv_d;
            rate_q <= rate_d;
            rate_per_q <= rate_per_d;
            strap_done_q <= 1'b1;
        end
    end

    // Read mux; reserved bits show their fixed values
    always @* begin
        rd_d = 8'h00;
        case (reg_addr)
            `SWFP_ADDR_UUC: rd_d = {`SWFP_UUC_RSV, uuc_q};
            `SWFP_ADDR_UMC: rd_d = {drv_q, umc_q};
            `SWFP_ADDR_UVID: rd_d = {2'h0, uvid_q};
            `SWFP_ADDR_SFIP: rd_d = {1'b0, sfip_q};
            `SWFP_ADDR_RATE: rd_d = {2'h0, rate_per_q, rate_q, 2'h0};
            `SWFP_ADDR_REV: rd_d = {REV_ID, 4'h0};
            `SWFP_ADDR_DSCP0: rd_d = dscp_q[7:0];
            `SWFP_ADDR_DSCP1: rd_d = dscp_q[15:8];
            default: begin
                if (mac_sel(reg_addr)) begin
                    rd_d = mac_byte(mac_q, reg_addr[2:0]);
                end
            end
        endcase
    end

    // Port map and enable of the looked-up class
    always @* begin
        case (lkp_class)
            `SWFP_CLASS_UUC: sel_d = uuc_q;
            `SWFP_CLASS_UMC: sel_d = umc_q;
            `SWFP_CLASS_UVID: sel_d = uvid_q;
            `SWFP_CLASS_UIPMC: sel_d = sfip_q[5:0];
            default: sel_d = 6'h00;
        endcase
    end

    // Bit n-1 is port n
    always @* begin
        map_d = fwd_map(sel_d);
    end

    always @* begin
        self_hit_d = sfip_q[`SWFP_BIT_SELF_FILT] && (lkp_da == mac_q);
    end

    always @* begin
        prio_d = dscp_pick(dscp_all, tos_byte[7:2]);
    end

    // Register port answer
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rd_d;
            end
        end
    end

    // Lookup answer, held until the next lookup
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fwd_valid_q <= 1'b0;
            fwd_special_q <= 1'b0;
            fwd_port_map_q <= 5'h00;
            self_drop_q <= 1'b0;
        end else begin
            fwd_valid_q <= lkp_valid;
            if (lkp_valid) begin
                fwd_special_q <= sel_d[`SWFP_BIT_FWD_EN];
                fwd_port_map_q <= map_d;
                self_drop_q <= self_hit_d;
            end
        end
    end

    // Priority answer, held until the next request
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prio_valid_q <= 1'b0;
            prio_q <= 2'h0;
        end else begin
            prio_valid_q <= tos_valid;
            if (tos_valid) begin
                prio_q <= prio_d;
            end
        end
    end

    // Configuration copies, one cycle behind their fields
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drive_strength_q <= `SWFP_RST_DRV;
            ingress_period_q <= `SWFP_RST_RATE_PER;
            egress_queue_mode_q <= 1'b0;
            pvid_per_source_q <= 1'b0;
        end else begin
            drive_strength_q <= drv_q;
            ingress_period_q <= rate_per_q;
            egress_queue_mode_q <= rate_q[1];
            pvid_per_source_q <= rate_q[0];
        end
    end

endmodule // swfp_regs

// ===== shared/swfp_defs.vh
// Summary of operation
// - Bit 5 enables unknown-unicast port map
// - Bits 4-0 unicast map; 0 filters, ones floods
// - Bit 5 enables unknown non-IP multicast map
// - Multicast map: zero filters, bits select ports
// - Bit 5 enables unknown-VLAN-ID forwarding map
// - Unknown-VID map: zero filters, ones all five
// - Bit 5 enables unknown IP multicast map
// - IP multicast map: zero filters, ones floods
// - Bit 6 filters frames with own address
// - Self-address filtering applied at egress port
// - Own address is six bytes, one value
// - Drive strength loads from strap, upper inverted
// - Ingress period 00=16ms, 01=64ms, 1x=256ms
// - Bit 3 selects queue-based egress limiting
// - Bit 2 selects per-source-port PVID insertion
// - Read-only revision nibble, lower nibble reserved
// - Upper six TOS bits decode 64 entries
// - Code v priority at bits 2v+1:2v
// - Second map register holds codes 4 to 7
// - Priority 3 highest queue, 0 lowest
`ifndef SWFP_DEFS_VH
`define SWFP_DEFS_VH

`define SWFP_ADDR_MAC0 8'h68
`define SWFP_ADDR_MAC5 8'h6D
`define SWFP_ADDR_UUC 8'h83
`define SWFP_ADDR_UMC 8'h84
`define SWFP_ADDR_UVID 8'h85
`define SWFP_ADDR_SFIP 8'h86
`define SWFP_ADDR_RATE 8'h87
`define SWFP_ADDR_REV 8'h89
`define SWFP_ADDR_DSCP0 8'h90
`define SWFP_ADDR_DSCP1 8'h91

`define SWFP_BIT_FWD_EN 5
`define SWFP_BIT_SELF_FILT 6
`define SWFP_BIT_EGR_QUEUE 3
`define SWFP_BIT_PVID_SEL 2

`define SWFP_RST_MAC 48'h0010_A1FF_FFFF
`define SWFP_RST_RATE_PER 2'h1
`define SWFP_RST_MAP 6'h00
`define SWFP_RST_SFIP 7'h00
`define SWFP_RST_DSCP 16'h0000
`define SWFP_RST_DRV 2'h1
`define SWFP_RST_EGR 2'h0
`define SWFP_UUC_RSV 2'h2

`define SWFP_CLASS_UUC 2'h0
`define SWFP_CLASS_UMC 2'h1
`define SWFP_CLASS_UVID 2'h2
`define SWFP_CLASS_UIPMC 2'h3

`define SWFP_PER_16MS 16
`define SWFP_PER_64MS 64
`define SWFP_PER_256MS 256

`endif

// ===== test/swfp_regs_assertions.sv
`timescale 1ns/1ns
module swfp_regs_chk (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire lkp_valid,
    input wire fwd_valid_q,
    input wire fwd_special_q,
    input wire [4:0] fwd_port_map_q,
    input wire tos_valid,
    input wire [7:0] tos_byte,
    input wire prio_valid_q,
    input wire [1:0] prio_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_uuc_fixed: assert property (reg_rd && reg_addr == 8'h83 |=> reg_rdata_q[7:6] == 2'b10)
        else $error("bad fixed bits");
    chk_rate_rsv: assert property (reg_rd && reg_addr == 8'h87 |=> (reg_rdata_q & 8'hC3) == 0)
        else $error("bad rate bits");
    chk_rev_low: assert property (reg_rd && reg_addr == 8'h89 |=> reg_rdata_q[3:0] == 0)
        else $error("bad revision low");
    chk_lkp_answer: assert property (lkp_valid |=> fwd_valid_q)
        else $error("no lookup answer");
    chk_off_map: assert property (fwd_valid_q && !fwd_special_q |-> fwd_port_map_q == 0)
        else $error("map while disabled");
    chk_map_held: assert property (!lkp_valid |=> $stable(fwd_port_map_q))
        else $error("map moved");
    chk_tos_answer: assert property (tos_valid |=> prio_valid_q)
        else $error("no priority answer");
    chk_high_code: assert property (tos_valid && tos_byte[7:5] != 0 |=> prio_q == 0)
        else $error("bad high code");
endmodule // swfp_regs_chk
bind swfp_regs swfp_regs_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .lkp_valid(lkp_valid), .fwd_valid_q(fwd_valid_q),
    .fwd_special_q(fwd_special_q), .fwd_port_map_q(fwd_port_map_q), .tos_valid(tos_valid),
    .tos_byte(tos_byte), .prio_valid_q(prio_valid_q), .prio_q(prio_q));

// ===== test/swfp_regs_bench.sv
`timescale 1ns/1ns
module swfp_regs_bench;
    reg clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, lkp_valid = 0, tos_valid = 0;
    reg strap_drive = 1;
    reg [7:0] reg_addr = 0, reg_wdata = 0, tos_byte = 0;
    reg [1:0] lkp_class = 0;
    reg [47:0] lkp_da = 0;
    wire [7:0] rdq;
    wire [4:0] mapq;
    wire [1:0] prio_q, drv, per;
    wire rvq, fvq, spq, sdq, pvq, egq, pvs;
    integer error_cnt = 0, checks_done = 0, v;
    always #20 clk_sys = ~clk_sys;
    swfp_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdq), .reg_rvalid_q(rvq),
        .strap_drive(strap_drive), .lkp_valid(lkp_valid), .lkp_class(lkp_class), .lkp_da(lkp_da),
        .fwd_valid_q(fvq), .fwd_special_q(spq), .fwd_port_map_q(mapq), .self_drop_q(sdq),
        .tos_valid(tos_valid), .tos_byte(tos_byte), .prio_valid_q(pvq), .prio_q(prio_q),
        .drive_strength_q(drv), .ingress_period_q(per), .egress_queue_mode_q(egq),
        .pvid_per_source_q(pvs));
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 cmp(rdq, e);
        cmp({7'h00, rvq}, 8'h01);
    endtask
    task lk(input [1:0] c, input [47:0] da, input [7:0] e);
        @(posedge clk_sys);
        lkp_class <= c;
        lkp_da <= da;
        lkp_valid <= 1;
        @(posedge clk_sys);
        lkp_valid <= 0;
        #1 cmp({fvq, spq, sdq, mapq}, e);
    endtask
    task tq(input [7:0] b, input [1:0] p);
        @(posedge clk_sys);
        tos_byte <= b;
        tos_valid <= 1;
        @(posedge clk_sys);
        tos_valid <= 0;
        #1 cmp({pvq, prio_q}, {6'h1, p});
    endtask
    task t_reset;
        rd(8'h83, 8'h80);
        rd(8'h84, 8'h40);
        rd(8'h68, 8'h00);
        rd(8'h69, 8'h10);
        rd(8'h87, 8'h10);
        rd(8'h89, 8'h90);
        rd(8'h91, 8'h00);
        rd(8'hA0, 8'h00);
        cmp({drv, per, egq, pvs, 2'b0}, 8'h50);
        $display("reset test done");
    endtask
    task t_fwd;
        for (v = 0; v < 4; v = v + 1) begin
            wr(8'h83 + v, {v == 0, 2'b01, 5'h1F >> v});
            lk(v, 0, {3'b110, 5'h1F >> v});
            wr(8'h83 + v, {v == 0, 2'b00, 5'h1F});
            lk(v, 0, 8'h80);
        end
        wr(8'h85, 8'h20);
        lk(2, 0, 8'hC0);
        rd(8'h83, 8'h9F);
        $display("forward test done");
    endtask
    task t_self;
        wr(8'h86, 8'h61);
        lk(3, 48'h0010_A1FF_FFFF, 8'hE1);
        lk(3, 48'h0010_A1FF_FFFE, 8'hC1);
        wr(8'h6D, 8'hFE);
        lk(3, 48'h0010_A1FF_FFFE, 8'hE1);
        wr(8'h86, 8'h21);
        lk(3, 48'h0010_A1FF_FFFE, 8'hC1);
        $display("self test done");
    endtask
    task t_rate;
        wr(8'h87, 8'h3C);
        rd(8'h87, 8'h3C);
        cmp({drv, per, egq, pvs, 2'b0}, 8'h3C);
        wr(8'h89, 8'hF0);
        rd(8'h89, 8'h90);
        wr(8'h87, 8'h20);
        rd(8'h87, 8'h20);
        cmp({drv, per, egq, pvs, 2'b0}, 8'h20);
        wr(8'h87, 8'h00);
        rd(8'h87, 8'h00);
        cmp({drv, per, egq, pvs, 2'b0}, 8'h00);
        $display("rate test done");
    endtask
    task t_prio;
        wr(8'h90, 8'hE4);
        wr(8'h91, 8'h1B);
        for (v = 0; v < 8; v = v + 1)
            tq({v[5:0], 2'b11}, v < 4 ? v : 7 - v);
        tq(8'h20, 2'h0);
        $display("priority test done");
    endtask
    task t_strap;
        @(posedge clk_sys);
        strap_drive <= 0;
        rstn <= 0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1;
        rd(8'h84, 8'h80);
        rd(8'h90, 8'h00);
        cmp({drv, per, egq, pvs, 2'b0}, 8'h90);
        $display("strap test done");
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1;
        t_reset;
        t_fwd;
        t_self;
        t_rate;
        t_prio;
        t_strap;
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        print_verdict;
    end
endmodule // swfp_regs_bench
